// >>> core/sld_map.svh
// offsets, field positions, reset values and timing counts of the segment display driver
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SLD_OFF_CTRL      12'h000
`define SLD_OFF_BANK      12'h004
`define SLD_OFF_PTR2      12'h008
`define SLD_OFF_IDATA     12'h00C
`define SLD_OFF_CFG       12'h010
`define SLD_OFF_STAT      12'h014
`define SLD_OFF_GP_BASE   12'h200
`define SLD_OFF_GP_LAST   12'h3FC

// ****************************************
// field positions
// ****************************************
`define SLD_CTRL_ON_BIT   0
`define SLD_CTRL_SEG_LO   1
`define SLD_CTRL_SEG_HI   4
`define SLD_CTRL_HALT_BIT 5
`define SLD_CFG_SRC_LO    0
`define SLD_CFG_SRC_HI    1
`define SLD_CFG_DIV_LO    2
`define SLD_CFG_DIV_HI    4
`define SLD_CFG_DUTY_LO   5
`define SLD_CFG_DUTY_HI   6
`define SLD_CFG_BIAS_BIT  7

// ****************************************
// reset values and memory geometry
// ****************************************
`define SLD_CTRL_RST      8'h00
`define SLD_CFG_RST       8'h00
`define SLD_PIX_FIRST     8'h40
`define SLD_PIX_LAST      8'h60
`define SLD_PIX_WORDS     33
`define SLD_GP_WORDS      128
`define SLD_SEG_COUNT     33

// ****************************************
// timing counts
// ****************************************
`define SLD_SYS_PRESCALE  2'h3
`define SLD_WDT_RATIO_M1  8'h03
`define SLD_RTC_RATIO_M1  8'h07
`define SLD_DIV_MIN_EXP   2
`define SLD_DIV_MAX_SEL   3'h6
`define SLD_SLOT_LEN_2COM 5'h11
`define SLD_SLOT_LEN_3COM 5'h0B
`define SLD_SLOT_LEN_4COM 5'h09
`define SLD_FRAME_MIN     65
`define SLD_FRAME_MAX     72

`endif

// >>> core/sld_pkg.sv
// types shared by the segment display driver files
package sld_pkg;

  // display source clock choice
  typedef enum logic [1:0] {
    SRC_WDT = 2'b00,
    SRC_RTC = 2'b01,
    SRC_SYS = 2'b10
  } sld_src_e;

  // duty choice
  typedef enum logic [1:0] {
    DUTY_2 = 2'b00,
    DUTY_3 = 2'b01,
    DUTY_4 = 2'b10
  } sld_duty_e;

  // pin level code handed to the analog ladder
  typedef enum logic [1:0] {
    LVL_VSS = 2'b00,
    LVL_VC  = 2'b01,
    LVL_VB  = 2'b10,
    LVL_VA  = 2'b11
  } sld_lvl_e;

  // register decode result
  typedef enum logic [2:0] {
    DEC_CTRL  = 3'b000,
    DEC_BANK  = 3'b001,
    DEC_PTR2  = 3'b010,
    DEC_IDATA = 3'b011,
    DEC_CFG   = 3'b100,
    DEC_STAT  = 3'b101,
    DEC_GP    = 3'b110,
    DEC_NONE  = 3'b111
  } sld_dec_e;

endpackage

// >>> core/sld_clkdiv.sv
// display clock divider: source choice and power-of-two ratio, gives a one-cycle tick
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_clkdiv (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] src_sel,
  input  wire logic [2:0] div_sel,
  // oscillator pins from other domains
  input  wire logic       wdt_osc,
  input  wire logic       rtc_osc,
  // display clock enable
  output logic            disp_tick
);

  logic       wdt_meta_q, wdt_sync_q, wdt_prev_q;
  logic       rtc_meta_q, rtc_sync_q, rtc_prev_q;
  logic [1:0] pre_q;
  logic [7:0] cnt_q;
  logic       tick_q;
  logic       src_tick;
  logic [7:0] ratio_m1;
  logic [2:0] div_eff;

  // oscillator synchronisers; edge detect looks only at the second and third stages
  always_ff @(posedge clock) begin
    wdt_meta_q <= wdt_osc;
    wdt_sync_q <= wdt_meta_q;
    wdt_prev_q <= wdt_sync_q;
    rtc_meta_q <= rtc_osc;
    rtc_sync_q <= rtc_meta_q;
    rtc_prev_q <= rtc_sync_q;
  end

  assign div_eff = (div_sel > `SLD_DIV_MAX_SEL) ? `SLD_DIV_MAX_SEL : div_sel;
  assign src_tick = (src_sel == sld_pkg::SRC_WDT) ? (wdt_sync_q & ~wdt_prev_q) :
                    (src_sel == sld_pkg::SRC_RTC) ? (rtc_sync_q & ~rtc_prev_q) :
                    (src_sel == sld_pkg::SRC_SYS) ? (pre_q == `SLD_SYS_PRESCALE) : 1'b0;
  assign ratio_m1 = (src_sel == sld_pkg::SRC_WDT) ? `SLD_WDT_RATIO_M1 :
                    (src_sel == sld_pkg::SRC_RTC) ? `SLD_RTC_RATIO_M1 :
                    8'((9'h001 << (4'(div_eff) + 4'(`SLD_DIV_MIN_EXP))) - 9'h001);

  // prescaler and ratio counter; both held cleared while stopped to save power
  always_ff @(posedge clock) begin
    if (!resetn || !run) begin
      pre_q  <= 2'h0;
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_q + 2'h1;
      tick_q <= 1'b0;
      if (src_tick) begin
        if (cnt_q >= ratio_m1) begin
          cnt_q  <= 8'h00;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  assign disp_tick = tick_q;

  property p_tick_ratio;
    @(posedge clock) disable iff (!resetn)
      (run && $past(run) && src_tick && cnt_q >= ratio_m1) |=> disp_tick;
  endproperty
  a_tick_ratio: assert property (p_tick_ratio) else $error("display tick missing at ratio end");

  property p_stop_quiet;
    @(posedge clock) disable iff (!resetn)
      !run |=> !disp_tick;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("tick while divider stopped");

endmodule // sld_clkdiv

// >>> core/sld_top.sv
// segment display driver: register slave, banked pixel memory and waveform sequencer
// Function
// - pixel memory sits at 40H-60H in bank one
// - waveforms follow pixel memory with no refresh
// - bank bit zero keeps access in general memory
// - bank bit one, indirect 40H-60H reaches pixels
// - direct addressing always hits bank zero memory
// - four-common layout for quarter duty, three for third duty, two for half duty
// - driver-enable bit switches whole driver on/off
// - four select bits give pins to port
// - source is watchdog, real-time or system/4
// - watchdog source divided by four only
// - real-time source divided by eight only
// - system/4 source divided by 2^2 to 2^8
// - 4kHz display clock gives 55-62Hz frame
// - duty sets common count and slots
// - 33x2, 33x3, 32x4 with half/third bias
// - waveforms keep each pixel DC-free
// - option keeps driver running during halt
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sld_map.svh"

module sld_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // oscillators and core state
  input  wire logic        wdt_osc,
  input  wire logic        rtc_osc,
  input  wire logic        cpu_halt,
  // panel drive level codes
  output logic [7:0]       com_level,
  output logic [65:0]      seg_level,
  // pin sharing with the fourth port and status
  output logic [3:0]       port_owns_pin,
  output logic             driver_active
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  pix_mem [0:`SLD_PIX_WORDS-1];
  logic [7:0]  gp_mem  [0:`SLD_GP_WORDS-1];
  logic [7:0]  ctrl_q, cfg_q, ptr2_q;
  logic        bank_q;
  logic        aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  slot_q;
  logic        phase_q;
  logic [4:0]  half_cnt_q;
  logic        active_q;
  logic [7:0]  com_q;
  logic [65:0] seg_q;
  logic [65:0] seg_d;
  logic [7:0]  com_d;

  // decode of a bus address into a register select
  function automatic sld_pkg::sld_dec_e dec_fn(input logic [11:0] a);
    if (a[1:0] != 2'b00) begin
      return sld_pkg::DEC_NONE;
    end else if (a == `SLD_OFF_CTRL) begin
      return sld_pkg::DEC_CTRL;
    end else if (a == `SLD_OFF_BANK) begin
      return sld_pkg::DEC_BANK;
    end else if (a == `SLD_OFF_PTR2) begin
      return sld_pkg::DEC_PTR2;
    end else if (a == `SLD_OFF_IDATA) begin
      return sld_pkg::DEC_IDATA;
    end else if (a == `SLD_OFF_CFG) begin
      return sld_pkg::DEC_CFG;
    end else if (a == `SLD_OFF_STAT) begin
      return sld_pkg::DEC_STAT;
    end else if (a >= `SLD_OFF_GP_BASE && a <= `SLD_OFF_GP_LAST) begin
      return sld_pkg::DEC_GP;
    end else begin
      return sld_pkg::DEC_NONE;
    end
  endfunction

  // level code of one pin for the given drive state
  function automatic logic [1:0] lvl_fn(input logic is_seg, input logic on,
                                        input logic ph, input logic b13);
    if (!is_seg) begin
      return on ? (ph ? sld_pkg::LVL_VA : sld_pkg::LVL_VSS)
                : (b13 ? (ph ? sld_pkg::LVL_VC : sld_pkg::LVL_VB) : sld_pkg::LVL_VB);
    end else begin
      return on ? (ph ? sld_pkg::LVL_VSS : sld_pkg::LVL_VA)
                : (b13 ? (ph ? sld_pkg::LVL_VB : sld_pkg::LVL_VC)
                       : (ph ? sld_pkg::LVL_VA : sld_pkg::LVL_VSS));
    end
  endfunction

  // ****************************************
  // bus decode and memory steering
  // ****************************************
  sld_pkg::sld_dec_e wr_dec, rd_dec;
  logic       wr_fire, rd_fire;
  logic       ptr_in_pix, ind_to_pix;
  logic [5:0] pix_idx;
  logic [6:0] gp_wr_idx, gp_rd_idx, ptr_gp_idx;
  logic [7:0] ind_rd;
  logic       drv_on, run_in_halt, bias13;
  logic [1:0] ncom_m1;
  logic [4:0] slot_len;
  logic       disp_tick, cfg_wr;

  assign wr_dec  = dec_fn(awaddr_q);
  assign rd_dec  = dec_fn(s_axi_araddr);
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign cfg_wr  = wr_fire && wlane_q && wr_dec == sld_pkg::DEC_CFG;
  assign ptr_in_pix = (ptr2_q >= `SLD_PIX_FIRST) && (ptr2_q <= `SLD_PIX_LAST);
  assign ind_to_pix = bank_q && ptr_in_pix;
  assign pix_idx    = 6'(ptr2_q - `SLD_PIX_FIRST);
  assign ptr_gp_idx = ptr2_q[6:0];
  assign gp_wr_idx  = awaddr_q[8:2];
  assign gp_rd_idx  = s_axi_araddr[8:2];
  assign ind_rd     = ind_to_pix ? pix_mem[pix_idx] : gp_mem[ptr_gp_idx];

  assign drv_on      = ctrl_q[`SLD_CTRL_ON_BIT];
  assign run_in_halt = ctrl_q[`SLD_CTRL_HALT_BIT];
  assign bias13      = cfg_q[`SLD_CFG_BIAS_BIT];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // address and data are caught in either order, then committed together
  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
      awaddr_q <= 12'h000;
      wdata_q  <= 8'h00;
      wlane_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_dec == sld_pkg::DEC_NONE) ? 2'b11 : 2'b00;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // register writes; only the low byte lane carries data
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl_q <= `SLD_CTRL_RST;
      cfg_q  <= `SLD_CFG_RST;
      bank_q <= 1'b0;
      ptr2_q <= 8'h00;
    end else if (wr_fire && wlane_q) begin
      if (wr_dec == sld_pkg::DEC_CTRL) ctrl_q <= wdata_q;
      if (wr_dec == sld_pkg::DEC_CFG)  cfg_q  <= wdata_q;
      if (wr_dec == sld_pkg::DEC_BANK) bank_q <= wdata_q[0];
      if (wr_dec == sld_pkg::DEC_PTR2) ptr2_q <= wdata_q;
    end
  end

  // memory kept: contents survive the driver being off, no reset on purpose
  always_ff @(posedge clock) begin
    if (wr_fire && wlane_q && wr_dec == sld_pkg::DEC_IDATA) begin
      if (ind_to_pix) pix_mem[pix_idx] <= wdata_q;
      else            gp_mem[ptr_gp_idx] <= wdata_q;
    end
    if (wr_fire && wlane_q && wr_dec == sld_pkg::DEC_GP) gp_mem[gp_wr_idx] <= wdata_q;
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= (rd_dec == sld_pkg::DEC_NONE) ? 2'b11 : 2'b00;
      case (rd_dec)
        sld_pkg::DEC_CTRL:  rdata_q <= {24'h00_0000, ctrl_q};
        sld_pkg::DEC_BANK:  rdata_q <= {31'h0000_0000, bank_q};
        sld_pkg::DEC_PTR2:  rdata_q <= {24'h00_0000, ptr2_q};
        sld_pkg::DEC_IDATA: rdata_q <= {24'h00_0000, ind_rd};
        sld_pkg::DEC_CFG:   rdata_q <= {24'h00_0000, cfg_q};
        sld_pkg::DEC_STAT:  rdata_q <= {28'h000_0000, active_q, phase_q, slot_q};
        sld_pkg::DEC_GP:    rdata_q <= {24'h00_0000, gp_mem[gp_rd_idx]};
        default:            rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // display clock and frame sequencer
  // ****************************************
  sld_clkdiv u_div (
    .clock     (clock),
    .resetn    (resetn),
    .run       (active_q),
    .src_sel   (cfg_q[`SLD_CFG_SRC_HI:`SLD_CFG_SRC_LO]),
    .div_sel   (cfg_q[`SLD_CFG_DIV_HI:`SLD_CFG_DIV_LO]),
    .wdt_osc   (wdt_osc),
    .rtc_osc   (rtc_osc),
    .disp_tick (disp_tick)
  );

  // commons per duty; slot length keeps the frame near 60Hz at 4kHz
  assign ncom_m1  = (cfg_q[`SLD_CFG_DUTY_HI:`SLD_CFG_DUTY_LO] == sld_pkg::DUTY_4) ? 2'h3 :
                    (cfg_q[`SLD_CFG_DUTY_HI:`SLD_CFG_DUTY_LO] == sld_pkg::DUTY_3) ? 2'h2 : 2'h1;
  assign slot_len = (ncom_m1 == 2'h3) ? `SLD_SLOT_LEN_4COM :
                    (ncom_m1 == 2'h2) ? `SLD_SLOT_LEN_3COM : `SLD_SLOT_LEN_2COM;

  // each slot runs two halves of opposite polarity so every pixel averages zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      active_q   <= 1'b0;
      slot_q     <= 2'h0;
      phase_q    <= 1'b0;
      half_cnt_q <= 5'h00;
    end else begin
      active_q <= drv_on && !(cpu_halt && !run_in_halt);
      if (!active_q || cfg_wr) begin // restart so a new duty never sees a stale slot
        slot_q     <= 2'h0;
        phase_q    <= 1'b0;
        half_cnt_q <= 5'h00;
      end else if (disp_tick) begin
        if (half_cnt_q >= slot_len - 5'h01) begin
          half_cnt_q <= 5'h00;
          phase_q    <= !phase_q;
          if (phase_q) slot_q <= (slot_q >= ncom_m1) ? 2'h0 : slot_q + 2'h1;
        end else begin
          half_cnt_q <= half_cnt_q + 5'h01;
        end
      end
    end
  end

  // ****************************************
  // waveform levels
  // ****************************************
  // common levels; unused commons rest at ground
  always_comb begin
    com_d = 8'h00;
    for (int c = 0; c < 4; c++) begin
      if (active_q && 2'(c) <= ncom_m1)
        com_d[2*c +: 2] = lvl_fn(1'b0, slot_q == 2'(c), phase_q, bias13);
    end
  end

  // segment levels read straight from pixel memory
  genvar g;
  generate
    for (g = 0; g < `SLD_SEG_COUNT; g++) begin : g_seg
      logic gone;
      assign gone = !active_q || (g < 4 && ctrl_q[`SLD_CTRL_SEG_LO + (g % 4)]) ||
                    (g == `SLD_SEG_COUNT - 1 && ncom_m1 == 2'h3);
      assign seg_d[2*g +: 2] = gone ? sld_pkg::LVL_VSS
                             : lvl_fn(1'b1, pix_mem[g][slot_q], phase_q, bias13);
    end
  endgenerate

  // level codes leave from flops
  always_ff @(posedge clock) begin
    if (!resetn) begin
      com_q <= 8'h00;
      seg_q <= '0;
    end else begin
      com_q <= com_d;
      seg_q <= seg_d;
    end
  end

  assign com_level     = com_q;
  assign seg_level     = seg_q;
  assign port_owns_pin = ctrl_q[`SLD_CTRL_SEG_HI:`SLD_CTRL_SEG_LO];
  assign driver_active = active_q;

  // ****************************************
  // checks
  // ****************************************
  logic [7:0] frame_cnt_q;
  logic       frame_end, frame_seen_q;
  assign frame_end = active_q && disp_tick && phase_q && slot_q == ncom_m1 &&
                     half_cnt_q >= slot_len - 5'h01;
  always_ff @(posedge clock) begin
    if (!resetn || !active_q || cfg_wr) begin
      frame_cnt_q  <= 8'h00;
      frame_seen_q <= 1'b0;
    end else if (frame_end) begin
      frame_cnt_q  <= 8'h00;
      frame_seen_q <= 1'b1;
    end else if (disp_tick) begin
      frame_cnt_q <= frame_cnt_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_frame_len; frame_end && frame_seen_q |->
    frame_cnt_q + 8'h01 >= 8'(`SLD_FRAME_MIN) && frame_cnt_q + 8'h01 <= 8'(`SLD_FRAME_MAX);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length off");
  property p_off_quiet; !drv_on |=> ##1 com_level == 8'h00 && seg_level == '0; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("drive while off");
  property p_halt_stop; cpu_halt && !run_in_halt |=> ##1 com_level == 8'h00; endproperty
  a_halt_stop: assert property (p_halt_stop) else $error("drive during halt");
  property p_port_pin; ctrl_q[`SLD_CTRL_SEG_LO] |=> seg_level[1:0] == 2'b00; endproperty
  a_port_pin: assert property (p_port_pin) else $error("port pin still driven");
  property p_bank0; wr_fire && wr_dec == sld_pkg::DEC_IDATA && !bank_q && ptr_in_pix |=>
    pix_mem[$past(pix_idx)] == $past(pix_mem[pix_idx]);
  endproperty
  a_bank0: assert property (p_bank0) else $error("pixel written in bank zero");
  property p_bank1; wr_fire && wlane_q && wr_dec == sld_pkg::DEC_IDATA && ind_to_pix |=>
    pix_mem[$past(pix_idx)] == $past(wdata_q);
  endproperty
  a_bank1: assert property (p_bank1) else $error("pixel write lost");
  property p_direct; wr_fire && wr_dec == sld_pkg::DEC_GP && awaddr_q[8:2] == 7'h40 |=>
    pix_mem[0] == $past(pix_mem[0]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct access hit pixels");
  property p_slot_range; slot_q <= ncom_m1 || !active_q; endproperty
  a_slot_range: assert property (p_slot_range) else $error("slot beyond duty");
  property p_sel_com; active_q && $past(active_q) |->
    com_level[2*$past(slot_q) +: 2] == ($past(phase_q) ? sld_pkg::LVL_VA : sld_pkg::LVL_VSS);
  endproperty
  a_sel_com: assert property (p_sel_com) else $error("selected common level wrong");
  property p_seg_follow; active_q && $past(active_q) && !$past(ctrl_q[`SLD_CTRL_SEG_HI]) |->
    seg_level[7:6] == lvl_fn(1'b1, $past(pix_mem[3][slot_q]), $past(phase_q), $past(bias13));
  endproperty
  a_seg_follow: assert property (p_seg_follow) else $error("segment not following memory");

endmodule // sld_top

// >>> bench/sld_panel.sv
// panel model: watches pixel common 0 / segment 0 and sums its drive over each frame
`timescale 1ns/1ps

module sld_panel (
  // clock
  input  wire logic        clock,
  // drive level codes from the driver, bias choice from the bench
  input  wire logic [7:0]  com_level,
  input  wire logic [65:0] seg_level,
  input  wire logic        bias_third,
  // level sum of the pixel over the last whole frame
  output int               frame_dc
);
  int         acc_q = 0;
  logic [1:0] com0_q;
  // level code to sixths of the panel voltage; half bias puts the middle level mid-rail
  function automatic int volt(input logic [1:0] c);
    return (c == 2'b11) ? 6 : (c == 2'b10) ? (bias_third ? 4 : 3) : (c == 2'b01) ? 2 : 0;
  endfunction
  // ****************************************
  // frame balance
  // ****************************************
  // pixel dc sum: a frame starts where common 0 first reaches the top level
  always @(posedge clock) begin
    com0_q <= com_level[1:0];
    if (com_level[1:0] == 2'b11 && com0_q != 2'b11) begin
      frame_dc <= acc_q;
      acc_q    <= volt(com_level[1:0]) - volt(seg_level[1:0]);
    end else begin
      acc_q <= acc_q + volt(com_level[1:0]) - volt(seg_level[1:0]);
    end
  end
endmodule // sld_panel

// >>> bench/segment_lcd_driver_tb.sv
// self-checking bench of the segment display driver
`timescale 1ns/1ps
`include "sld_map.svh"

module segment_lcd_driver_tb;
  logic        clock, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, wdt_osc, rtc_osc, cpu_halt, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, driver_active, bias_third;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, port_owns_pin, sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  com_level, p, dg, dp;
  logic [65:0] seg_level;
  int          err_count, samples_checked, cyc, frame_dc;
  // ****************************************
  // instances, clocks, timeout
  // ****************************************
  sld_top   u_dut (.*);
  sld_panel u_panel (.*);
  // oscillators are slow and unrelated to the bus clock
  initial begin clock = 0; forever #2 clock = ~clock; end
  initial begin wdt_osc = 0; forever #20 wdt_osc = ~wdt_osc; end
  initial begin rtc_osc = 0; forever #28 rtc_osc = ~rtc_osc; end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin err_count++; close_out(); end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus master: each channel held until its own ready, response stalled at random
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'($urandom), d};
    s_axi_wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready === 1'b1) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (!wd && s_axi_wready === 1'b1) begin wd = 1; s_axi_wvalid <= 1'b0; end
    end
    repeat ($urandom_range(2)) @(posedge clock);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axr(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0000, ed});
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // cycles from one rise of common 0 to its top level to the next
  task automatic rise(output int n);
    n = 0;
    do begin @(negedge clock); n++; end while (com_level[1:0] == 2'b11);
    do begin @(negedge clock); n++; end while (com_level[1:0] != 2'b11);
  endtask
  // frame = two halves of slot_len ticks per common; first frame skipped after a change
  task automatic frame(input int duty, input int tick, input logic [1:0] e0, input logic [1:0] e32);
    int n, len;
    len = (duty == 0) ? 17 : (duty == 1) ? 11 : 9;
    rise(n);
    rise(n);
    rise(n);
    chk(32'(n), 32'(2 * len * (duty + 2) * tick));
    chk(32'(n / tick >= 65 && n / tick <= 72), 32'h0000_0001);
    chk(32'(seg_level[1:0]), 32'(e0));
    chk(32'(seg_level[65:64]), 32'(e32));
    repeat (2) @(negedge clock);
    chk(32'(frame_dc), 32'h0000_0000);
  endtask
  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, cpu_halt, bias_third, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(28));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    axr(`SLD_OFF_CTRL, 8'h00, 2'b00);
    axr(`SLD_OFF_CFG, 8'h00, 2'b00);
    axr(12'h018, 8'h00, 2'b11);
    axw(12'h018, 8'h55, 2'b11);
    $display("test reset done");
    // every pixel byte gets a defined value before any check reads one
    axw(`SLD_OFF_BANK, 8'h01, 2'b00);
    for (int k = 0; k < 33; k++) begin
      axw(`SLD_OFF_PTR2, 8'h40 + 8'(k), 2'b00);
      axw(`SLD_OFF_IDATA, 8'($urandom), 2'b00);
    end
    for (int i = 0; i < 8; i++) begin
      p  = (i == 0) ? 8'h40 : (i == 1) ? 8'h60 : 8'h40 + 8'($urandom_range(32));
      dg = 8'($urandom);
      dp = 8'($urandom);
      axw(`SLD_OFF_BANK, 8'h00, 2'b00);
      axw(`SLD_OFF_PTR2, p, 2'b00);
      axw(`SLD_OFF_IDATA, dg, 2'b00);
      axw(`SLD_OFF_BANK, 8'h01, 2'b00);
      axw(`SLD_OFF_IDATA, dp, 2'b00);
      axr(`SLD_OFF_IDATA, dp, 2'b00);
      axr(12'h200 + {2'b00, p, 2'b00}, dg, 2'b00);
      axw(`SLD_OFF_BANK, 8'h00, 2'b00);
      axr(`SLD_OFF_IDATA, dg, 2'b00);
    end
    axw(12'h300, 8'h5A, 2'b00);
    axr(12'h300, 8'h5A, 2'b00);
    $display("test banked memory done");
    axw(`SLD_OFF_BANK, 8'h01, 2'b00);
    axw(`SLD_OFF_PTR2, 8'h60, 2'b00);
    axw(`SLD_OFF_IDATA, 8'h00, 2'b00);
    axw(`SLD_OFF_PTR2, 8'h40, 2'b00);
    axw(`SLD_OFF_IDATA, 8'h01, 2'b00);
    sel = {3'($urandom), 1'b0};
    axw(`SLD_OFF_CTRL, {3'b000, sel, 1'b1}, 2'b00);
    repeat (3) @(negedge clock);
    chk(32'(port_owns_pin), 32'(sel));
    chk(32'(driver_active), 32'h0000_0001);
    // system source with the shortest divider for short frames
    for (int d = 0; d < 3; d++) begin
      axw(`SLD_OFF_CFG, {1'b0, 2'(d), 5'b00010}, 2'b00);
      frame(d, 16, 2'b00, (d == 2) ? 2'b00 : 2'b11);
    end
    axw(`SLD_OFF_CFG, 8'h46, 2'b00);
    frame(2, 32, 2'b00, 2'b00);
    axw(`SLD_OFF_CFG, 8'h00, 2'b00);
    frame(0, 40, 2'b00, 2'b11);
    axw(`SLD_OFF_IDATA, 8'h00, 2'b00);
    bias_third <= 1'b1;
    axw(`SLD_OFF_CFG, 8'h81, 2'b00);
    frame(0, 112, 2'b10, 2'b10);
    $display("test waveforms done");
    @(posedge clock);
    cpu_halt <= 1'b1;
    repeat (3) @(negedge clock);
    chk(32'(driver_active), 32'h0000_0000);
    axw(`SLD_OFF_CTRL, 8'h3F, 2'b00);
    repeat (3) @(negedge clock);
    chk(32'(driver_active), 32'h0000_0001);
    chk(32'(port_owns_pin), 32'h0000_000F);
    axw(`SLD_OFF_PTR2, 8'h50, 2'b00);
    axw(`SLD_OFF_IDATA, 8'hC3, 2'b00);
    cpu_halt <= 1'b0;
    axw(`SLD_OFF_CTRL, 8'h00, 2'b00);
    repeat (3) @(negedge clock);
    chk(32'(driver_active), 32'h0000_0000);
    chk(32'(com_level), 32'h0000_0000);
    axr(`SLD_OFF_IDATA, 8'hC3, 2'b00);
    $display("test halt and off done");
    close_out();
  end
endmodule // segment_lcd_driver_tb
